// ===== verilog/lsh_pkg.sv
package lsh_pkg;

    // ------------------------------------------------------------------
    // clock and link timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 50;
    localparam int SCLK_HALF_NS    = 250;
    localparam int CS_GAP_NS       = 500;
    localparam int SCLK_HALF_CYC   = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_GAP_CYC      = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W           = 4;

    // ------------------------------------------------------------------
    // controller register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_LEN     = 8'h08;
    localparam logic [7:0]  OFS_TEMP    = 8'h0C;
    localparam logic [7:0]  OFS_DATA    = 8'h20;
    localparam int          DATA_DEPTH  = 8;
    localparam logic [3:0]  LEN_RESET   = 4'h1;

    // control register fields
    localparam int CTRL_GO     = 0;
    localparam int CTRL_READ   = 1;
    localparam int CTRL_RS     = 2;
    localparam int CTRL_DOUBLE = 3;

    // status register fields
    localparam int STAT_BUSY     = 0;
    localparam int STAT_DONE     = 1;
    localparam int STAT_MISMATCH = 2;
    localparam int STAT_VALID    = 3;

    // ------------------------------------------------------------------
    // link byte layouts
    // ------------------------------------------------------------------
    localparam int          SUB_DIR_BIT        = 7;
    localparam logic [1:0]  DEVICE_SUBADDRESS  = 2'h1;
    localparam int          CTRL_CONTINUE_BIT  = 7;
    localparam int          CTRL_PAYLOAD_BIT   = 6;

    typedef enum logic [2:0] {
        LSH_IDLE,
        LSH_LEAD,
        LSH_CLK_LO,
        LSH_CLK_HI,
        LSH_TRAIL,
        LSH_GAP
    } lsh_state_t;

endpackage : lsh_pkg

// ===== verilog/lsh_sync3.sv
module lsh_sync3 (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // asynchronous level in, filtered level out
    input  wire logic async_in,
    output logic      level_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // ------------------------------------------------------------------
    // three stages; level moves only when stages two and three agree
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_q      <= 1'b0;
            s2_q      <= 1'b0;
            s3_q      <= 1'b0;
            level_out <= 1'b0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_out <= s3_q;
            end
        end
    end

endmodule : lsh_sync3

// ===== verilog/lsh_host.sv
//Function
// R1 - device acknowledges only matching address pin
// R2 - control byte precedes command or display bytes
// R3 - device stores display bytes at pointer
// R4 - only addressed device acknowledges bytes
// R5 - access ends cleanly after last byte
// R6 - read direction bit fetches temperature byte
// R7 - chip select high resets device port
// R8 - device samples data on rising clock
// R9 - device changes read data on falling
// R10 - host toggles chip select between transfers
// R11 - bytes shifted most significant bit first
// R12 - first byte after select is subaddress
// R13 - subaddress bits six-five must be 01
// R14 - subaddress bit seven selects direction
// R15 - write sends control byte after subaddress
// R16 - temperature read uses direction bit high
// R17 - device drives data after last subaddress bit
// R18 - read twice, accept when both agree
// R19 - device releases data at select high
// R20 - host drives data line after release
// R21 - control byte: continue flag, payload select
// R22 - device address 011100, pin, direction
// R23 - device drives only acknowledge, readout
// R24 - device releases line after unacknowledged readout
//
// Design decisions made here: the address-and-strobe port and the register offsets.
module lsh_host
    import lsh_pkg::*;
(
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    // software register port
    input  wire logic [lsh_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    output logic      [31:0]               reg_rdata,
    // three-wire link
    output logic                           link_cs_n,
    output logic                           link_sclk,
    output logic                           link_sdio_o,
    output logic                           link_sdio_oe_n,
    input  wire logic                      link_sdio_i
);
    import lsh_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    lsh_state_t       state_q;
    lsh_state_t       state_d;
    logic [CNT_W-1:0] tick_q;
    logic [2:0]       bit_q;
    logic [3:0]       byte_q;
    logic [7:0]       rx_q;
    logic [7:0]       temp_q;
    logic [7:0]       first_q;
    logic             second_q;
    logic             busy_q;
    logic             done_q;
    logic             mismatch_q;
    logic             valid_q;
    logic             dir_read_q;
    logic             rs_q;
    logic             double_q;
    logic [3:0]       len_q;
    logic [7:0]       data_mem [DATA_DEPTH];
    logic             sdio_lvl;

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    function automatic logic [7:0] sub_byte(input logic rd);
        sub_byte = {rd, DEVICE_SUBADDRESS, 5'h00}; // R12 R13 R14 R16 R6
    endfunction : sub_byte

    function automatic logic [7:0] ctl_byte(input logic rs);
        logic [7:0] b;
        b = 8'h00;
        b[CTRL_CONTINUE_BIT] = 1'b0; // R21
        b[CTRL_PAYLOAD_BIT]  = rs;   // R21
        ctl_byte = b;
    endfunction : ctl_byte

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        reg_hit = (a == ofs);
    endfunction : reg_hit

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    wire        wr_ctrl   = reg_write && reg_hit(reg_addr, OFS_CTRL);
    wire        wr_status = reg_write && reg_hit(reg_addr, OFS_STATUS);
    wire        wr_len    = reg_write && reg_hit(reg_addr, OFS_LEN);
    wire        in_data   = (reg_addr[7:5] == OFS_DATA[7:5]) && (reg_addr[1:0] == 2'h0);
    wire        wr_data   = reg_write && in_data;
    wire [2:0]  data_idx  = reg_addr[4:2];
    wire        go        = wr_ctrl && reg_wdata[CTRL_GO] && !busy_q;
    wire        clr_done  = wr_status && reg_wdata[STAT_DONE];

    wire [31:0] rd_ctrl   = {28'h0000000, double_q, rs_q, dir_read_q, 1'b0};
    wire [31:0] rd_status = {28'h0000000, valid_q, mismatch_q, done_q, busy_q};
    wire [31:0] rd_mux    = reg_hit(reg_addr, OFS_CTRL)   ? rd_ctrl :
                            reg_hit(reg_addr, OFS_STATUS) ? rd_status :
                            reg_hit(reg_addr, OFS_LEN)    ? {28'h0000000, len_q} :
                            reg_hit(reg_addr, OFS_TEMP)   ? {24'h000000, temp_q} :
                            in_data                       ? {24'h000000, data_mem[data_idx]} :
                                                            32'h00000000;

    // ------------------------------------------------------------------
    // link sequencing decode
    // ------------------------------------------------------------------
    wire        half_done = (tick_q == CNT_W'(SCLK_HALF_CYC - 1));
    wire        gap_done  = (tick_q == CNT_W'(CS_GAP_CYC - 1));
    wire        last_bit  = (bit_q == 3'h7);
    // write: subaddress, one control byte, then payload; read: subaddress, readout
    wire [3:0]  last_byte = dir_read_q ? 4'h1 : (len_q + 4'h1);   // R2 R15
    wire        is_last   = (byte_q == last_byte);
    wire        rx_byte   = dir_read_q && (byte_q != 4'h0);
    wire [3:0]  next_byte = byte_q + 4'h1;
    wire [2:0]  pay_idx   = 3'(next_byte - 4'h2);
    wire [7:0]  nxt_tx    = (next_byte == 4'h1) ? ctl_byte(rs_q) : data_mem[pay_idx];
    wire        next_rx   = dir_read_q;
    // a fresh start takes its direction from the write that launches it
    wire        start_rd  = go ? reg_wdata[CTRL_READ] : dir_read_q;
    wire [7:0]  sub_tx    = sub_byte(start_rd);
    wire [7:0]  rx_full   = {rx_q[6:0], sdio_lvl};
    // second pass pending once the first readout has been captured
    wire        again     = double_q && dir_read_q && second_q;
    logic [7:0] tx_q;

    // ------------------------------------------------------------------
    // input synchroniser for the returned data line
    // ------------------------------------------------------------------
    lsh_sync3 u_sdio_sync (
        .clock     (clock),
        .rst_n     (rst_n),
        .async_in  (link_sdio_i),
        .level_out (sdio_lvl)
    );

    // ------------------------------------------------------------------
    // state transitions
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            LSH_IDLE:   if (go) state_d = LSH_LEAD;
            LSH_LEAD:   if (half_done) state_d = LSH_CLK_LO;
            LSH_CLK_LO: if (half_done) state_d = LSH_CLK_HI;
            LSH_CLK_HI: if (half_done) state_d = (last_bit && is_last) ? LSH_TRAIL : LSH_CLK_LO;
            LSH_TRAIL:  if (half_done) state_d = LSH_GAP;
            LSH_GAP:    if (gap_done) state_d = again ? LSH_LEAD : LSH_IDLE;
            default:    state_d = LSH_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= LSH_IDLE;
            tick_q  <= '0;
        end else begin
            state_q <= state_d;
            tick_q  <= (state_d != state_q || state_q == LSH_IDLE) ? '0 : tick_q + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // link pins and shifters
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            link_cs_n      <= 1'b1;
            link_sclk      <= 1'b0;
            link_sdio_o    <= 1'b0;
            link_sdio_oe_n <= 1'b0;
            bit_q          <= 3'h0;
            byte_q         <= 4'h0;
            tx_q           <= 8'h00;
            rx_q           <= 8'h00;
        end else begin
            case (state_q)
                LSH_IDLE, LSH_GAP: begin
                    if (state_d == LSH_LEAD) begin
                        link_cs_n   <= 1'b0;                 // R12
                        tx_q        <= {sub_tx[6:0], 1'b0};
                        link_sdio_o <= sub_tx[7];            // R11
                        bit_q       <= 3'h0;
                        byte_q      <= 4'h0;
                    end
                end
                LSH_CLK_LO: begin
                    if (half_done) begin
                        link_sclk <= 1'b1;
                    end
                end
                LSH_CLK_HI: begin
                    if (half_done) begin
                        link_sclk <= 1'b0;
                        if (rx_byte) begin
                            rx_q <= rx_full;                 // R11
                        end
                        bit_q <= bit_q + 3'h1;
                        if (!last_bit) begin
                            link_sdio_o <= tx_q[7];          // R11
                            tx_q        <= {tx_q[6:0], 1'b0};
                        end else if (!is_last) begin
                            byte_q <= next_byte;
                            if (next_rx) begin
                                link_sdio_oe_n <= 1'b1;      // R6 R16
                            end else begin
                                link_sdio_o <= nxt_tx[7];
                                tx_q        <= {nxt_tx[6:0], 1'b0};
                            end
                        end
                    end
                end
                LSH_TRAIL: begin
                    if (half_done) begin
                        link_cs_n      <= 1'b1;              // R10 R5
                        link_sdio_oe_n <= 1'b0;              // R20
                        link_sdio_o    <= 1'b1;              // R20
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // readout capture and double-read check
    // ------------------------------------------------------------------
    wire rx_end = (state_q == LSH_CLK_HI) && half_done && last_bit && is_last && dir_read_q;
    wire finish = (state_q == LSH_GAP) && gap_done && !again;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            temp_q     <= 8'h00;
            first_q    <= 8'h00;
            second_q   <= 1'b0;
            mismatch_q <= 1'b0;
            valid_q    <= 1'b0;
        end else begin
            if (go) begin
                second_q   <= 1'b0;
                mismatch_q <= 1'b0;
                valid_q    <= 1'b0;
            end else if (rx_end) begin
                temp_q <= rx_full;
                if (double_q && !second_q) begin
                    first_q  <= rx_full;
                    second_q <= 1'b1;
                end else begin
                    second_q   <= 1'b0;
                    mismatch_q <= double_q && (rx_full != first_q);  // R18
                    valid_q    <= !double_q || (rx_full == first_q); // R18
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dir_read_q <= 1'b0;
            rs_q       <= 1'b0;
            double_q   <= 1'b0;
            len_q      <= LEN_RESET;
            busy_q     <= 1'b0;
            done_q     <= 1'b0;
            reg_rdata  <= 32'h00000000;
        end else begin
            if (wr_ctrl && !busy_q) begin
                dir_read_q <= reg_wdata[CTRL_READ];
                rs_q       <= reg_wdata[CTRL_RS];
                double_q   <= reg_wdata[CTRL_DOUBLE];
            end
            if (wr_len && !busy_q) begin
                len_q <= (reg_wdata[3:0] > 4'(DATA_DEPTH)) ? 4'(DATA_DEPTH) : reg_wdata[3:0];
            end
            busy_q    <= go ? 1'b1 : (finish ? 1'b0 : busy_q);
            done_q    <= finish ? 1'b1 : (clr_done ? 1'b0 : done_q);
            reg_rdata <= reg_read ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge clock) begin
        if (wr_data && !busy_q) begin
            data_mem[data_idx] <= reg_wdata[7:0];
        end
    end

endmodule : lsh_host

// ===== test/lsh_host_assertions.sv
module lsh_host_assertions (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // three-wire link
    input wire logic link_cs_n,
    input wire logic link_sclk,
    input wire logic link_sdio_o,
    input wire logic link_sdio_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // link framing and timing
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_lead;
        !link_sclk[*8] ##1 !link_sclk[*2] ##1 link_sclk;
    endsequence
    sequence s_gap;
        link_cs_n[*8] ##1 link_cs_n ##1 link_cs_n;
    endsequence

    property p_idle_clk;
        link_cs_n |-> !link_sclk;
    endproperty
    property p_lead;
        $fell(link_cs_n) |-> s_lead;
    endproperty
    property p_high;
        $rose(link_sclk) |-> link_sclk[*5] ##1 !link_sclk;
    endproperty
    property p_low;
        $fell(link_sclk) |-> !link_sclk[*5];
    endproperty
    property p_data;
        !link_cs_n && !link_sdio_oe_n && !$fell(link_cs_n) && $changed(link_sdio_o)
            |-> $fell(link_sclk);
    endproperty
    property p_turn;
        $rose(link_sdio_oe_n) |-> $fell(link_sclk) && !link_cs_n;
    endproperty
    property p_release;
        $rose(link_cs_n) |-> !link_sdio_oe_n && link_sdio_o;
    endproperty
    property p_own;
        link_sdio_oe_n |-> !link_cs_n;
    endproperty
    property p_gap;
        $rose(link_cs_n) |-> s_gap;
    endproperty

    a_idle_clk: assert property (p_idle_clk) else $error("clock runs while idle");
    a_lead: assert property (p_lead) else $error("lead phase wrong");
    a_high: assert property (p_high) else $error("clock high phase wrong");
    a_low: assert property (p_low) else $error("clock low phase short");
    a_data: assert property (p_data) else $error("data moved off falling edge");
    a_turn: assert property (p_turn) else $error("release off falling edge");
    a_release: assert property (p_release) else $error("line not driven at end");
    a_own: assert property (p_own) else $error("line released while idle");
    a_gap: assert property (p_gap) else $error("select gap short");
endmodule : lsh_host_assertions

bind lsh_host lsh_host_assertions u_lsh_host_assertions (
    .clock(clock), .rst_n(rst_n), .link_cs_n(link_cs_n), .link_sclk(link_sclk),
    .link_sdio_o(link_sdio_o), .link_sdio_oe_n(link_sdio_oe_n)
);

// ===== test/lsh_dev_model.sv
module lsh_dev_model (
    // link pins
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic       sdio,
    // temperature source
    input  wire logic [7:0] temp,
    // data line drive
    output logic            dout,
    output logic            drive
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh_q, tx_q;
    logic       sel, rd;
    int         nbit = 0;
    logic [7:0] rx_q[$];

    initial begin
        drive = 1'b0;
        dout  = 1'b0;
    end
    always @(posedge cs_n) begin
        nbit  = 0;
        sel   = 1'b0;
        drive = 1'b0;
    end
    always @(posedge sclk) begin
        if (!cs_n) begin
            sh_q = {sh_q[6:0], sdio};
            nbit = nbit + 1;
            if (nbit == 8) begin
                sel = (sh_q[6:5] == 2'h1);
                rd  = sh_q[7];
            end else if (nbit % 8 == 0 && sel && !rd) begin
                rx_q.push_back(sh_q);
            end
        end
    end
    always @(negedge sclk) begin
        if (!cs_n && sel && rd && nbit >= 8) begin
            if (nbit == 8) tx_q = temp;
            drive = 1'b1;
            dout  = (nbit < 16) ? tx_q[15 - nbit] : ~dout;
        end
    end
endmodule : lsh_dev_model

// ===== test/tb_top.sv
module tb_top
    import lsh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
    logic        clock = 1'b0, rst_n = 1'b0, flt = 1'b0;
    logic [7:0]  reg_addr, temp, b, tv;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic        reg_write, reg_read, link_cs_n, link_sclk, link_sdio_o, link_sdio_oe_n;
    logic        sdio_w, dout, drive;
    int          err_count = 0, checks_done = 0, len;
    logic [7:0]  exp_q[$];

    always #(CLK_PERIOD_NS / 2) clock = ~clock;
    always @(posedge clock) flt <= ~flt;
    // a released line toggles every clock, so lsh_sync3 keeps the last driven level
    assign sdio_w = !link_sdio_oe_n ? link_sdio_o : drive ? dout : flt;

    lsh_host u_lsh_host (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .link_cs_n(link_cs_n), .link_sclk(link_sclk), .link_sdio_o(link_sdio_o),
        .link_sdio_oe_n(link_sdio_oe_n), .link_sdio_i(sdio_w)
    );
    lsh_dev_model u_lsh_dev_model (
        .cs_n(link_cs_n), .sclk(link_sclk), .sdio(sdio_w), .temp(temp), .dout(dout),
        .drive(drive)
    );

    // ------------------------------------------------------------------
    // register bus and waits
    // ------------------------------------------------------------------
    task automatic print_verdict;
        if (err_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
        d = reg_rdata;
    endtask : rd
    task automatic wait_cs(input logic lvl);
        int n;
        n = 0;
        while (link_cs_n !== lvl && n < 2000) begin
            @(posedge clock);
            n++;
        end
        if (n == 2000) begin
            err_count++;
            print_verdict();
        end
    endtask : wait_cs
    task automatic wait_done;
        int n;
        n = 0;
        rd(OFS_STATUS, rv);
        while (rv[STAT_BUSY] !== 1'b0 && n < 2000) begin
            rd(OFS_STATUS, rv);
            n++;
        end
        if (n == 2000) begin
            err_count++;
            print_verdict();
        end
        `CHK("done", 1'b1, rv[STAT_DONE])
        wr(OFS_STATUS, 32'h2);
    endtask : wait_done

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read  = 1'b0;
        temp      = 8'h00;
        void'($urandom(32'h4EB8));
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        rd(OFS_LEN, rv);
        `CHK("len reset", 32'h1, rv)
        rd(8'h10, rv);
        `CHK("unmapped", 32'h0, rv)
        for (int t = 0; t < 6; t++) begin
            len = (t > 3) ? t + 4 : (t == 3) ? 2 + $urandom % 6 : t;
            exp_q = {8'((t % 2) * 64)};
            for (int i = 0; i < 8; i++) begin
                b = 8'($urandom);
                wr(OFS_DATA + 8'(4 * i), {24'h0, b});
                if (i < len) exp_q.push_back(b);
            end
            u_lsh_dev_model.rx_q.delete();
            wr(OFS_LEN, 32'(len));
            wr(OFS_CTRL, 32'((t % 2) << CTRL_RS) | 32'h1);
            wr(OFS_LEN, 32'h3);
            wr(OFS_CTRL, 32'h1);
            wait_done();
            rd(OFS_LEN, rv);
            `CHK("len", 32'((len > 8) ? 8 : len), rv)
            `CHK("rx count", exp_q.size(), u_lsh_dev_model.rx_q.size())
            foreach (exp_q[i]) `CHK("rx byte", exp_q[i], u_lsh_dev_model.rx_q[i])
        end
        for (int t = 0; t < 3; t++) begin
            tv = 8'($urandom);
            temp <= tv;
            wr(OFS_CTRL, (t == 0) ? 32'h3 : 32'hB);
            if (t == 2) begin
                wait_cs(1'b0);
                wait_cs(1'b1);
                temp <= ~tv;
            end
            wait_done();
            rd(OFS_STATUS, rv);
            `CHK("valid", t != 2, rv[STAT_VALID])
            `CHK("mismatch", t == 2, rv[STAT_MISMATCH])
            rd(OFS_TEMP, rv);
            `CHK("temp", (t == 2) ? ~tv : tv, rv[7:0])
        end
        wr(OFS_CTRL, 32'h3);
        repeat (120) @(posedge clock);
        rst_n <= 1'b0;
        @(posedge clock);
        `CHK("select idle", 1'b1, link_cs_n)
        `CHK("host drives", 1'b0, link_sdio_oe_n)
        @(posedge clock);
        rst_n <= 1'b1;
        rd(OFS_LEN, rv);
        `CHK("len after reset", 32'h1, rv)
        print_verdict();
    end
endmodule : tb_top
